// file: pkg/sadc_pkg.sv
package sadc_pkg;

   localparam int CLK_MHZ = 125;
   localparam logic [1:0] ADDR_CTRL_A = 2'h0;
   localparam logic [1:0] ADDR_CONF_B = 2'h1;
   localparam logic [1:0] ADDR_RES_HI = 2'h2;
   localparam logic [1:0] ADDR_RES_LO = 2'h3;

   // Field positions in conv_control_a.
   localparam int CA_CH_LSB = 4;
   localparam int CA_DONE = 3;
   localparam int CA_ACTIVE = 2;
   localparam int CA_REFSW = 1;
   localparam int CA_START = 0;

   // Field positions in conv_config_b.
   localparam int CB_EIGHT = 7;
   localparam int CB_STIME_LSB = 5;
   localparam int CB_TRIGSEL = 4;
   localparam int CB_IRQEN = 3;
   localparam int CB_AUTO = 2;
   localparam int CB_CLK_LSB = 0;

   localparam logic [7:0] CTRL_A_RESET = 8'h00;
   localparam logic [7:0] CONF_B_RESET = 8'h00;
   localparam logic [9:0] RESULT_RESET = 10'h000;

   // Interrupt identity presented to the interrupt controller.
   localparam logic [4:0] IRQ_NUMBER = 5'h12;
   localparam logic [15:0] VEC_UPPER_ADDR = 16'hffd6;
   localparam logic [15:0] VEC_LOWER_ADDR = 16'hffd7;

   // Sampling count base in conversion clock ticks; the sample time field is added to it.
   localparam logic [3:0] SAMPLE_BASE = 4'h4;
   localparam logic [3:0] NUM_BITS_10 = 4'ha;
   localparam logic [3:0] NUM_BITS_8 = 4'h8;

   typedef enum logic [1:0] {
      SADC_IDLE = 2'b00,
      SADC_SAMPLE = 2'b01,
      SADC_COMPARE = 2'b10,
      SADC_STORE = 2'b11
   } sadc_state_t;

   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } sadc_bus_t;

   typedef struct packed {
      logic sample;
      logic hold;
      logic [3:0] channel;
      logic [9:0] dac_code;
      logic ref_switch;
   } sadc_analog_t;

endpackage

// file: design/sadc_ctrl.sv
// Contract
// RULE1 - Completion sets done flag regardless of interrupt enable.
// RULE2 - Interrupt request asserted while done flag and enable are both one.
// RULE3 - Writing zero to done flag clears it and withdraws the request.
// RULE4 - Service routine must clear done flag before returning.
// RULE5 - Completion interrupt is number 18, vector at FFD6 and FFD7.
// RULE6 - Auto trigger enable selects software or edge-triggered start.
// RULE7 - In software mode writing one to start begins a conversion.
// RULE8 - A start during conversion abandons it and starts afresh.
// RULE9 - With auto trigger on, each rising trigger edge starts conversion.
// RULE10 - Clearing auto trigger enable stops further edge starts.
// RULE11 - Start sets active flag and connects selected channel to hold.
// RULE12 - Input is sampled, then held fixed until conversion completes.
// RULE13 - Successive approximation MSB to LSB, then result to data regs.
// RULE14 - After result transfer active flag clears and done flag sets.
// RULE15 - Result registers keep the old value until a new completion.
// RULE16 - Software must not change the channel while converting.
// RULE17 - Reset, stop or watch mode halts conversion and clears active.
// RULE18 - Routine clears flag, reads result, then restarts by software.
// RULE19 - Ten-bit result upper two bits in result_high bits 1 and 0.
// RULE20 - Eight-bit mode puts result in result_low, result_high zero.
// RULE21 - Trigger select zero means none, one means the timer output.
// RULE22 - Restart coinciding with completion still sets the done flag.
// RULE23 - Interrupt request is a held level, not a pulse.
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module sadc_ctrl (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire sadc_pkg::sadc_bus_t bus_i,
   output logic [7:0] rdata_o,
   input wire logic stop_mode_i,
   input wire logic watch_mode_i,
   input wire logic timer_trigger_output_i,
   input wire logic cmp_i,
   input wire logic conv_tick_i,
   output sadc_pkg::sadc_analog_t analog_o,
   output logic irq_o,
   output logic [4:0] irq_num_o,
   output logic [15:0] irq_vec_hi_o,
   output logic [15:0] irq_vec_lo_o,
   output logic [1:0] conv_clock_select_o
);
   import sadc_pkg::*;

   logic [3:0] channel_q;
   logic [3:0] channel_d;
   logic done_q;
   logic done_d;
   logic active_q;
   logic active_d;
   logic refsw_q;
   logic refsw_d;
   logic [7:0] confb_q;
   logic [7:0] confb_d;
   logic [9:0] result_q;
   logic [9:0] result_d;
   logic [9:0] sar_q;
   logic [9:0] sar_d;
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic [3:0] bitpos_q;
   logic [3:0] bitpos_d;
   logic [2:0] trig_sync_q;
   logic [2:0] trig_sync_d;
   logic trig_prev_q;
   logic trig_prev_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   sadc_state_t state_q;
   sadc_state_t state_d;
   logic soft_start;
   logic edge_start;
   logic start;
   logic halt;
   logic finish;
   logic wr_ctrl_a;
   logic wr_conf_b;
   logic trig_level;
   logic [3:0] nbits;
   logic [9:0] trial_mask;

   // The timer output is asynchronous; an edge counts once stages agree.
   // A glitch seen by one stage only never starts a conversion, at the
   // cost of a few cycles of trigger latency.
   always_comb begin
      trig_sync_d = {trig_sync_q[1:0], timer_trigger_output_i};
      trig_prev_d = trig_prev_q;
      if (trig_sync_q[2] == trig_sync_q[1]) begin
         trig_prev_d = trig_sync_q[2];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         trig_sync_q <= 3'h0;
         trig_prev_q <= 1'b0;
      end else begin
         trig_sync_q <= trig_sync_d;
         trig_prev_q <= trig_prev_d;
      end
   end

   always_comb begin
      // RULE21 select trigger source.
      trig_level = confb_q[CB_TRIGSEL] & trig_sync_q[2] & trig_sync_q[1];
      // RULE9 rising edge start.
      // RULE10 auto gate off.
      edge_start = confb_q[CB_AUTO] & trig_level & ~trig_prev_q
                   & confb_q[CB_TRIGSEL];
      // A start write is refused while edge starting is switched on.
      // RULE7 software start bit.
      soft_start = bus_i.wr & (bus_i.addr == ADDR_CTRL_A)
                   & bus_i.wdata[CA_START] & ~confb_q[CB_AUTO];
      // RULE6 mode selection.
      start = confb_q[CB_AUTO] ? edge_start : soft_start;
      // RULE17 low-power halt.
      halt = stop_mode_i | watch_mode_i;
      nbits = confb_q[CB_EIGHT] ? NUM_BITS_8 : NUM_BITS_10;
      finish = (state_q == SADC_STORE);
      wr_ctrl_a = bus_i.wr & (bus_i.addr == ADDR_CTRL_A);
      wr_conf_b = bus_i.wr & (bus_i.addr == ADDR_CONF_B);
   end

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      bitpos_d = bitpos_q;
      sar_d = sar_q;
      result_d = result_q;
      active_d = active_q;
      done_d = done_q;
      channel_d = channel_q;
      refsw_d = refsw_q;
      confb_d = confb_q;
      if (wr_conf_b) begin
         confb_d = bus_i.wdata;
      end
      // Channel and switch follow every write; software keeps them still.
      if (wr_ctrl_a) begin
         channel_d = bus_i.wdata[CA_CH_LSB +: 4];
         refsw_d = bus_i.wdata[CA_REFSW];
         // RULE3 write zero clears.
         if (!bus_i.wdata[CA_DONE]) begin
            done_d = 1'b0;
         end
      end
      case (state_q)
         SADC_IDLE: begin
            state_d = SADC_IDLE;
         end
         // RULE12 sample phase.
         SADC_SAMPLE: begin
            if (conv_tick_i) begin
               // Sampling lasts one tick past the count, so zero is legal.
               if (cnt_q == 4'h0) begin
                  state_d = SADC_COMPARE;
                  bitpos_d = nbits - 4'h1;
                  sar_d = RESULT_RESET;
               end else begin
                  cnt_d = cnt_q - 4'h1;
               end
            end
         end
         // RULE13 successive approximation.
         SADC_COMPARE: begin
            if (conv_tick_i) begin
               // The bit under test takes the comparator verdict.
               sar_d[bitpos_q] = cmp_i;
               if (bitpos_q == 4'h0) begin
                  state_d = SADC_STORE;
               end else begin
                  bitpos_d = bitpos_q - 4'h1;
               end
            end
         end
         SADC_STORE: begin
            // RULE15 result only updated here.
            // RULE20 eight-bit upper zero.
            result_d = confb_q[CB_EIGHT] ? {2'h0, sar_q[7:0]} : sar_q;
            // RULE14 finish flags.
            active_d = 1'b0;
            // RULE1 set on completion.
            done_d = 1'b1;
            state_d = SADC_IDLE;
         end
         default: begin
            state_d = SADC_IDLE;
         end
      endcase
      // RULE8 restart abandons current.
      if (start) begin
         // RULE11 active and connect.
         active_d = 1'b1;
         state_d = SADC_SAMPLE;
         cnt_d = SAMPLE_BASE + {2'h0, confb_q[CB_STIME_LSB +: 2]};
         sar_d = RESULT_RESET;
      end
      // Low-power entry stops the sequence; flag and result are kept.
      if (halt) begin
         active_d = 1'b0;
         state_d = SADC_IDLE;
      end
      // RULE22 completion flag kept on restart.
      if (finish) begin
         done_d = 1'b1;
      end
   end

   always_comb begin
      rdata_d = 8'h00;
      if (bus_i.rd) begin
         case (bus_i.addr)
            ADDR_CTRL_A: begin
               rdata_d = {channel_q, done_q, active_q, refsw_q, 1'b0};
            end
            ADDR_CONF_B: begin
               rdata_d = confb_q;
            end
            // RULE19 upper bits placement.
            ADDR_RES_HI: begin
               rdata_d = {6'h00, result_q[9:8]};
            end
            ADDR_RES_LO: begin
               rdata_d = result_q[7:0];
            end
            default: begin
               rdata_d = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         state_q <= SADC_IDLE;
         cnt_q <= 4'h0;
         bitpos_q <= 4'h0;
         sar_q <= RESULT_RESET;
         result_q <= RESULT_RESET;
         active_q <= CTRL_A_RESET[CA_ACTIVE];
         done_q <= CTRL_A_RESET[CA_DONE];
         channel_q <= CTRL_A_RESET[CA_CH_LSB +: 4];
         refsw_q <= CTRL_A_RESET[CA_REFSW];
         confb_q <= CONF_B_RESET;
         rdata_q <= 8'h00;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         bitpos_q <= bitpos_d;
         sar_q <= sar_d;
         result_q <= result_d;
         active_q <= active_d;
         done_q <= done_d;
         channel_q <= channel_d;
         refsw_q <= refsw_d;
         confb_q <= confb_d;
         // Read data fall back to zero, so stale values never linger.
         rdata_q <= rdata_d;
      end
   end

   // The trial code drives the comparator reference; the trial bit is set.
   for (genvar b = 0; b < $bits(sar_q); b++) begin : g_trial
      assign trial_mask[b] = (state_q == SADC_COMPARE) && (bitpos_q == 4'(b));
   end

   always_comb begin
      analog_o.sample = (state_q == SADC_SAMPLE);
      analog_o.hold = (state_q == SADC_COMPARE) | (state_q == SADC_STORE);
      analog_o.channel = channel_q;
      analog_o.dac_code = sar_q | trial_mask;
      analog_o.ref_switch = refsw_q;
   end

   // A flag left set keeps the request up, so the routine is re-entered.
   // RULE2 level request.
   // RULE23 held while both true.
   assign irq_o = done_q & confb_q[CB_IRQEN];
   // RULE5 interrupt identity.
   assign irq_num_o = IRQ_NUMBER;
   assign irq_vec_hi_o = VEC_UPPER_ADDR;
   assign irq_vec_lo_o = VEC_LOWER_ADDR;
   assign rdata_o = rdata_q;
   assign conv_clock_select_o = confb_q[CB_CLK_LSB +: 2];
endmodule
`default_nettype wire

// file: tb/sadc_ctrl_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module sadc_chk (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire sadc_pkg::sadc_bus_t bus_i,
   input wire logic [7:0] rdata_o,
   input wire logic stop_mode_i,
   input wire logic watch_mode_i,
   input wire sadc_pkg::sadc_analog_t analog_o,
   input wire logic irq_o,
   input wire logic [4:0] irq_num_o,
   input wire logic [15:0] irq_vec_hi_o,
   input wire logic [15:0] irq_vec_lo_o,
   input wire logic [1:0] conv_clock_select_o
);
   import sadc_pkg::*;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   chk_irq_ident: assert property (irq_num_o == 5'h12 &&
      irq_vec_hi_o == 16'hffd6 && irq_vec_lo_o == 16'hffd7)
      else $error("interrupt identity wrong");
   chk_reset_quiet: assert property (disable iff (1'b0)
      reset_i |=> !irq_o && rdata_o == 8'h00 && !analog_o.hold)
      else $error("reset left outputs active");
   chk_mode_halt: assert property ((stop_mode_i || watch_mode_i)
      |=> !analog_o.sample && !analog_o.hold)
      else $error("low power mode did not halt");
   chk_enable_off: assert property (bus_i.wr &&
      bus_i.addr == ADDR_CONF_B && !bus_i.wdata[CB_IRQEN] |-> ##2 !irq_o)
      else $error("request stayed without enable");
   chk_done_clear: assert property (bus_i.wr &&
      bus_i.addr == ADDR_CTRL_A && bus_i.wdata[3:0] == 4'h0 &&
      !analog_o.hold && !analog_o.sample |-> ##2 !irq_o)
      else $error("request stayed after flag clear");
   chk_irq_level: assert property (irq_o && !bus_i.wr &&
      !$past(bus_i.wr) |=> irq_o)
      else $error("request dropped without a write");
   chk_hold_fixed: assert property (analog_o.hold &&
      $past(analog_o.hold) |-> $stable(analog_o.channel))
      else $error("channel moved while holding");
   chk_rdata_idle: assert property (!bus_i.rd |=> rdata_o == 8'h00)
      else $error("read data without a read");
   chk_clk_sel: assert property (bus_i.wr && bus_i.addr == ADDR_CONF_B
      |=> conv_clock_select_o == $past(bus_i.wdata[1:0]))
      else $error("clock select not taken");
endmodule
bind sadc_ctrl sadc_chk u_chk (.mclk_i, .reset_i, .bus_i, .rdata_o,
   .stop_mode_i, .watch_mode_i, .analog_o, .irq_o, .irq_num_o,
   .irq_vec_hi_o, .irq_vec_lo_o, .conv_clock_select_o);
`default_nettype wire

// file: tb/sadc_analog_model.sv
`timescale 1ns/1ns
`default_nettype none
module sadc_analog_model (
   input wire logic mclk_i,
   input wire logic [9:0] level_i,
   input wire sadc_pkg::sadc_analog_t analog_i,
   output logic cmp_o,
   output logic tick_o
);
   import sadc_pkg::*;
   logic [9:0] held_q = 10'h000;
   logic tick_q = 1'b0;
   always_ff @(posedge mclk_i) begin
      tick_q <= ~tick_q;
      if (analog_i.sample) begin
         held_q <= level_i;
      end
   end
   assign tick_o = tick_q;
   // trial code compare.
   // Outside hold the output toggles, so a stray sample is caught.
   assign cmp_o = analog_i.hold ? (held_q >= analog_i.dac_code) : tick_q;
endmodule
`default_nettype wire

// file: tb/sadc_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none
module sadc_ctrl_tb;
   import sadc_pkg::*;
   logic mclk_i = 1'b0;
   logic reset_i = 1'b1;
   logic stop_mode_i = 1'b0;
   logic watch_mode_i = 1'b0;
   logic timer_trigger_output_i = 1'b0;
   sadc_bus_t bus_i = '0;
   logic [9:0] level = 10'h000;
   logic [7:0] rdata_o;
   logic cmp_i, conv_tick_i, irq_o;
   sadc_analog_t analog_o;
   int err_count = 0;
   int cmp_count = 0;
   // Rows: config, level, expected upper and lower result.
   logic [27:0] rows [5] = '{{8'h09, 10'h2a5, 2'h2, 8'ha5},
      {8'h2a, 10'h3ff, 2'h3, 8'hff}, {8'h6b, 10'h000, 2'h0, 8'h00},
      {8'h48, 10'h17e, 2'h1, 8'h7e}, {8'h88, 10'h3ff, 2'h0, 8'hff}};
   logic [7:0] trg [3] = '{8'h1c, 8'h0c, 8'h18};
   sadc_ctrl uut (.mclk_i, .reset_i, .bus_i, .rdata_o, .stop_mode_i,
      .watch_mode_i, .timer_trigger_output_i, .cmp_i, .conv_tick_i,
      .analog_o, .irq_o, .irq_num_o(), .irq_vec_hi_o(), .irq_vec_lo_o(),
      .conv_clock_select_o());
   sadc_analog_model u_ana (.mclk_i, .level_i(level), .analog_i(analog_o),
      .cmp_o(cmp_i), .tick_o(conv_tick_i));
   always #4 mclk_i = ~mclk_i;
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      bus_i <= '{a, d, 1'b1, 1'b0};
      @(posedge mclk_i);
      bus_i <= '0;
      @(posedge mclk_i);
   endtask
   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      bus_i <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge mclk_i);
      bus_i <= '0;
      #1 chk(rdata_o, e);
      @(posedge mclk_i);
   endtask
   // A missing request is waited out for a bounded span only.
   task automatic wirq(input logic e);
      for (int i = 0; i < 300 && irq_o !== 1'b1; i++) @(posedge mclk_i);
      chk({7'h00, irq_o}, {7'h00, e});
   endtask
   task automatic end_sim;
      $display("Checks %0d, errors %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      #200000;
      err_count++;
      end_sim();
   end
   initial begin
      repeat (4) @(posedge mclk_i);
      reset_i <= 1'b0;
      @(posedge mclk_i);
      for (int a = 0; a < 4; a++) rd(2'(a), 8'h00);
      foreach (rows[i]) begin
         wr(ADDR_CONF_B, rows[i][27:20]);
         level <= rows[i][19:10];
         wr(ADDR_CTRL_A, {4'(i), 4'h1});
         wirq(1'b1);
         rd(ADDR_RES_HI, {6'h00, rows[i][9:8]});
         rd(ADDR_RES_LO, rows[i][7:0]);
         rd(ADDR_CTRL_A, {4'(i), 4'h8});
         wr(ADDR_CTRL_A, {4'(i), 4'h0});
         chk({7'h00, irq_o}, 8'h00);
      end
      wr(ADDR_CONF_B, 8'h08);
      level <= 10'h155;
      wr(ADDR_CTRL_A, 8'h01);
      repeat (12) @(posedge mclk_i);
      rd(ADDR_CTRL_A, 8'h04);
      rd(ADDR_RES_LO, 8'hff);
      level <= 10'h0aa;
      wr(ADDR_CTRL_A, 8'h01);
      wirq(1'b1);
      rd(ADDR_RES_LO, 8'haa);
      wr(ADDR_CTRL_A, 8'h00);
      wr(ADDR_CONF_B, 8'h00);
      wr(ADDR_CTRL_A, 8'h01);
      wirq(1'b0);
      rd(ADDR_CTRL_A, 8'h08);
      wr(ADDR_CONF_B, 8'h08);
      chk({7'h00, irq_o}, 8'h01);
      wr(ADDR_CTRL_A, 8'h00);
      for (int m = 0; m < 3; m++) begin
         wr(ADDR_CONF_B, trg[m]);
         timer_trigger_output_i <= 1'b1;
         repeat (4) @(posedge mclk_i);
         timer_trigger_output_i <= 1'b0;
         wirq(m == 0);
         wr(ADDR_CTRL_A, 8'h00);
      end
      for (int m = 0; m < 2; m++) begin
         wr(ADDR_CTRL_A, 8'h03);
         repeat (6) @(posedge mclk_i);
         {watch_mode_i, stop_mode_i} <= 2'(m + 1);
         @(posedge mclk_i);
         {watch_mode_i, stop_mode_i} <= 2'b00;
         rd(ADDR_CTRL_A, 8'h02);
         wirq(1'b0);
      end
      wr(ADDR_CONF_B, 8'h08);
      wr(ADDR_CTRL_A, 8'h01);
      repeat (6) @(posedge mclk_i);
      reset_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      reset_i <= 1'b0;
      @(posedge mclk_i);
      rd(ADDR_CTRL_A, 8'h00);
      rd(ADDR_RES_LO, 8'h00);
      wirq(1'b0);
      end_sim();
   end
endmodule
`default_nettype wire
